// file: sbm_master.sv
/*
 * System bus master: takes one transfer request at a time on the core
 * clock, wins the shared bus on the bus clock and runs the command.
 * Assumes the bus clock runs free and slaves answer with transfer done.
 */
`default_nettype none

module sbm_master (
    input  wire logic                        CLK,
    input  wire logic                        NRST,
    input  wire logic                        BUS_CLK,
    input  wire logic                        ANY_REQUEST_MODE,
    input  wire logic                        SHARED_REQ_GROUNDED,
    input  wire logic                        REQ_VALID,
    output var  logic                        REQ_READY,
    input  wire logic [sbm_pkg::KIND_W-1:0]  REQ_KIND,
    input  wire logic [sbm_pkg::ADDR_W-1:0]  REQ_ADDR,
    input  wire logic [sbm_pkg::DATA_W-1:0]  REQ_WDATA,
    input  wire logic                        REQ_UPPER_BYTE,
    input  wire logic                        REQ_HOLD,
    output var  logic                        RSP_VALID,
    output var  logic [sbm_pkg::DATA_W-1:0]  RSP_RDATA,
    input  wire logic                        PRIORITY_IN_N,
    output var  logic                        PRIORITY_OUT_N,
    output var  logic                        PARALLEL_REQUEST_N,
    input  wire logic                        BUS_IN_USE_N_I,
    output var  logic                        BUS_IN_USE_N_O,
    output var  logic                        BUS_IN_USE_N_OE,
    input  wire logic                        SHARED_REQUEST_N_I,
    output var  logic                        SHARED_REQUEST_N_O,
    output var  logic                        SHARED_REQUEST_N_OE,
    input  wire logic                        TRANSFER_DONE_N,
    output var  logic                        CTRL_OE,
    output var  logic [sbm_pkg::ADDR_W-1:0]  ADDR_LINES_N,
    input  wire logic [sbm_pkg::DATA_W-1:0]  DATA_LINES_N_I,
    output var  logic [sbm_pkg::DATA_W-1:0]  DATA_LINES_N_O,
    output var  logic                        DATA_LINES_N_OE,
    output var  logic                        MEM_READ_CMD_N,
    output var  logic                        MEM_WRITE_CMD_N,
    output var  logic                        IO_READ_CMD_N,
    output var  logic                        IO_WRITE_CMD_N,
    output var  logic                        INTR_ACK_N,
    output var  logic                        UPPER_BYTE_ENABLE_N,
    output var  logic                        RESOURCE_HOLD_N
);

    // ---------------- Core clock side ----------------
    logic                       ready_ff, nxt_ready;      // Free to take a request
    logic                       rsp_ff, nxt_rsp;          // Answer pulse
    logic [sbm_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;      // Answer data
    logic                       req_tgl_ff, nxt_req_tgl;  // Request event toggle
    logic                       ack_seen_ff, nxt_ack_seen;
    logic [sbm_pkg::KIND_W-1:0] kind_ff, nxt_kind;        // Held request words
    logic [sbm_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
    logic [sbm_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
    logic                       ube_ff, nxt_ube;
    logic                       hold_ff, nxt_hold;
    logic                       ack_s;                    // Synchronised answer toggle
    logic                       ack_tgl_ff;               // Bus side answer toggle
    logic [sbm_pkg::DATA_W-1:0] b_rdata_ff;               // Bus side read data, held

    sbm_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
        .clk   (CLK),
        .rst_n (NRST),
        .d     (ack_tgl_ff),
        .q     (ack_s)
    );

    // Request capture and answer return
    always_comb
    begin
        nxt_ready    = ready_ff;
        nxt_rsp      = 1'b0;
        nxt_rdata    = rdata_ff;
        nxt_req_tgl  = req_tgl_ff;
        nxt_ack_seen = ack_s;
        nxt_kind     = kind_ff;
        nxt_addr     = addr_ff;
        nxt_wdata    = wdata_ff;
        nxt_ube      = ube_ff;
        nxt_hold     = hold_ff;
        if (!ready_ff && (req_tgl_ff == ack_s) && (ack_s == ack_seen_ff))
        begin
            // Nothing outstanding, as just after reset: open for a request
            nxt_ready = 1'b1;
        end
        if (REQ_VALID && ready_ff)
        begin
            // Words stay put until the answer toggle comes back
            nxt_ready   = 1'b0;
            nxt_req_tgl = ~req_tgl_ff;
            nxt_kind    = REQ_KIND;
            nxt_addr    = REQ_ADDR;
            nxt_wdata   = REQ_WDATA;
            nxt_ube     = REQ_UPPER_BYTE;
            nxt_hold    = REQ_HOLD;
        end
        if (ack_s != ack_seen_ff)
        begin
            // Bus side finished; its read data is stable now
            nxt_ready = 1'b1;
            nxt_rsp   = 1'b1;
            nxt_rdata = b_rdata_ff;
        end
        if (!NRST)
        begin
            // Known state
            nxt_ready    = 1'b0;
            nxt_req_tgl  = 1'b0;
            nxt_ack_seen = 1'b0;
            nxt_rsp      = 1'b0;
            nxt_rdata    = '0;
        end
    end

    // Core side registers
    always_ff @(posedge CLK)
    begin
        ready_ff    <= nxt_ready;
        rsp_ff      <= nxt_rsp;
        rdata_ff    <= nxt_rdata;
        req_tgl_ff  <= nxt_req_tgl;
        ack_seen_ff <= nxt_ack_seen;
        kind_ff     <= nxt_kind;
        addr_ff     <= nxt_addr;
        wdata_ff    <= nxt_wdata;
        ube_ff      <= nxt_ube;
        hold_ff     <= nxt_hold;
    end

    assign REQ_READY = ready_ff;
    assign RSP_VALID = rsp_ff;
    assign RSP_RDATA = rdata_ff;

    // ---------------- Bus clock side ----------------
    logic                       b_rst_n;                  // Reset seen on bus clock
    logic [5:0]                 pin_s;                    // Synchronised pins and config
    logic [sbm_pkg::DATA_W-1:0] dat_s;                    // Synchronised data lines
    logic                       prio_s_n, busy_s_n, shared_request_n_s_n, transfer_done_n_s_n, any_s, gnd_s, req_s;

    sbm_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
        .clk   (BUS_CLK),
        .rst_n (1'b1),
        .d     (NRST),
        .q     (b_rst_n)
    );
    // Bus clock comes from the backplane; this master sources neither clock
    // No dual-port RAM on this side, so inhibit has nothing to gate
    // Pin stages run through reset so the mode pins reach the latch
    sbm_sync #(.W(7), .RST_VAL(7'h0f)) u_pin_sync (
        .clk   (BUS_CLK),
        .rst_n (1'b1),
        .d     ({req_tgl_ff, SHARED_REQ_GROUNDED, ANY_REQUEST_MODE, TRANSFER_DONE_N,
                 SHARED_REQUEST_N_I, BUS_IN_USE_N_I, PRIORITY_IN_N}),
        .q     ({req_s, pin_s})
    );
    sbm_sync #(.W(sbm_pkg::DATA_W), .RST_VAL('1)) u_dat_sync (
        .clk   (BUS_CLK),
        .rst_n (b_rst_n),
        .d     (DATA_LINES_N_I),
        .q     (dat_s)
    );
    assign {gnd_s, any_s, transfer_done_n_s_n, shared_request_n_s_n, busy_s_n, prio_s_n} = pin_s;

    sbm_pkg::sbm_state_t         st_ff, nxt_st;           // Sequencer state
    logic [sbm_pkg::CNT_W-1:0]   cnt_ff, nxt_cnt;         // Setup and recovery count
    logic                        seen_ff, nxt_seen;       // Last request toggle taken
    logic                        pend_ff, nxt_pend;       // Transfer outstanding
    logic                        nxt_ack_tgl;
    logic [sbm_pkg::DATA_W-1:0]  nxt_b_rdata;
    logic                        cfg_any_ff, nxt_cfg_any; // Mode latched at reset
    logic                        cfg_gnd_ff, nxt_cfg_gnd;
    logic                        busy_oe_ff, nxt_busy_oe; // Bus ownership
    logic                        shared_request_n_oe_ff, nxt_shared_request_n_oe;
    logic                        parallel_request_n_n_ff, nxt_parallel_request_n_n;
    logic                        priority_out_n_n_ff, nxt_priority_out_n_n;
    logic                        ctrl_oe_ff, nxt_ctrl_oe;
    logic [sbm_pkg::ADDR_W-1:0]  addr_n_ff, nxt_addr_n;
    logic [sbm_pkg::DATA_W-1:0]  dat_n_ff, nxt_dat_n;
    logic                        dat_oe_ff, nxt_dat_oe;
    logic [sbm_pkg::CMD_W-1:0]   cmd_n_ff, nxt_cmd_n;     // One bit per command line
    logic                        ube_n_ff, nxt_ube_n;
    logic                        hold_n_ff, nxt_hold_n;
    logic                        new_req, want, release_bus, is_wr;

    // Arbitration and command sequencing
    always_comb
    begin
        new_req     = req_s ^ seen_ff;
        nxt_seen    = req_s;
        nxt_pend    = pend_ff | new_req;
        want        = pend_ff | new_req;
        is_wr       = (kind_ff == sbm_pkg::KIND_MEM_WR) || (kind_ff == sbm_pkg::KIND_IO_WR);
        // Grounded: every cycle normal: lost priority or no need
        // any-request: shared request seen
        release_bus = cfg_gnd_ff | (~cfg_any_ff & (prio_s_n | ~want)) | (cfg_any_ff & ~shared_request_n_s_n);
        nxt_st      = st_ff;
        nxt_cnt     = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        nxt_ack_tgl = ack_tgl_ff;
        nxt_b_rdata = b_rdata_ff;
        nxt_cfg_any = cfg_any_ff;
        nxt_cfg_gnd = cfg_gnd_ff;
        nxt_busy_oe = busy_oe_ff;
        nxt_shared_request_n_oe = shared_request_n_oe_ff;
        nxt_ctrl_oe = ctrl_oe_ff;
        nxt_addr_n  = addr_n_ff;
        nxt_dat_n   = dat_n_ff;
        nxt_dat_oe  = dat_oe_ff;
        nxt_cmd_n   = cmd_n_ff;
        nxt_ube_n   = ube_n_ff;
        nxt_hold_n  = hold_n_ff;
        unique case (st_ff)
            sbm_pkg::ST_IDLE:
            begin
                if (want)
                begin
                    nxt_st = sbm_pkg::ST_ARB;
                end
            end
            sbm_pkg::ST_ARB:
            begin
                if (busy_s_n && !prio_s_n)
                begin
                    // Granted and bus free: take it, drop shared request
                    nxt_busy_oe = 1'b1;
                    nxt_shared_request_n_oe = 1'b0;
                    nxt_st      = sbm_pkg::ST_SETUP;
                    nxt_cnt     = sbm_pkg::ADDR_SETUP_CYC;
                end
                else if (!busy_s_n)
                begin
                    // Someone else owns it: ask to share
                    nxt_shared_request_n_oe = 1'b1;
                end
            end
            sbm_pkg::ST_SETUP:
            begin
                // Address, byte lane and write data ahead of the command
                nxt_ctrl_oe = 1'b1;
                nxt_addr_n  = ~addr_ff;
                nxt_ube_n   = ~ube_ff;
                nxt_hold_n  = ~hold_ff;
                nxt_dat_n   = ~wdata_ff;
                nxt_dat_oe  = is_wr;
                if (cnt_ff == '0)
                begin
                    // Exactly one command line goes low
                    nxt_cmd_n = ~(sbm_pkg::CMD_W'(1) << kind_ff);
                    nxt_st    = sbm_pkg::ST_CMD;
                end
            end
            sbm_pkg::ST_CMD:
            begin
                if (!transfer_done_n_s_n)
                begin
                    // Done seen: end command, keep read data
                    nxt_cmd_n   = sbm_pkg::CMD_IDLE_N;
                    nxt_b_rdata = ~dat_s;
                    nxt_ack_tgl = ~ack_tgl_ff;
                    nxt_pend    = new_req;   // A new request in the same cycle wins
                    nxt_cnt     = sbm_pkg::CMD_RECOV_CYC;
                    nxt_st      = sbm_pkg::ST_RECOV;
                end
            end
            sbm_pkg::ST_RECOV, sbm_pkg::ST_PARK:
            begin
                nxt_dat_oe = 1'b0;
                if ((st_ff == sbm_pkg::ST_RECOV) && (cnt_ff != '0))
                begin
                    nxt_st = sbm_pkg::ST_RECOV;
                end
                else if (release_bus)
                begin
                    // Give the bus back
                    nxt_busy_oe = 1'b0;
                    nxt_ctrl_oe = 1'b0;
                    nxt_hold_n  = 1'b1;
                    nxt_st      = sbm_pkg::ST_IDLE;
                end
                else if (want)
                begin
                    // Still owner: run next transfer without arbitration
                    nxt_st  = sbm_pkg::ST_SETUP;
                    nxt_cnt = sbm_pkg::ADDR_SETUP_CYC;
                end
                else
                begin
                    nxt_st = sbm_pkg::ST_PARK;
                end
            end
            default:
            begin
                nxt_st = sbm_pkg::ST_IDLE;
            end
        endcase
        // Request and priority chain outputs follow the need for the bus
        nxt_parallel_request_n_n = ~nxt_pend;
        nxt_priority_out_n_n = nxt_pend | nxt_busy_oe | prio_s_n;
        if (!b_rst_n)
        begin
            // Known state; mode sampled while in reset
            nxt_st      = sbm_pkg::ST_IDLE;
            nxt_cnt     = '0;
            nxt_seen    = 1'b0;
            nxt_pend    = 1'b0;
            nxt_ack_tgl = 1'b0;
            nxt_b_rdata = '0;
            nxt_cfg_any = any_s;
            nxt_cfg_gnd = gnd_s;
            nxt_busy_oe = 1'b0;
            nxt_shared_request_n_oe = 1'b0;
            nxt_parallel_request_n_n  = 1'b1;
            nxt_priority_out_n_n  = 1'b1;
            nxt_ctrl_oe = 1'b0;
            nxt_addr_n  = ~sbm_pkg::ADDR_IDLE;
            nxt_dat_n   = '1;
            nxt_dat_oe  = 1'b0;
            nxt_cmd_n   = sbm_pkg::CMD_IDLE_N;
            nxt_ube_n   = 1'b1;
            nxt_hold_n  = 1'b1;
        end
    end

    // Bus side registers
    always_ff @(posedge BUS_CLK)
    begin
        st_ff      <= nxt_st;
        cnt_ff     <= nxt_cnt;
        seen_ff    <= nxt_seen;
        pend_ff    <= nxt_pend;
        ack_tgl_ff <= nxt_ack_tgl;
        b_rdata_ff <= nxt_b_rdata;
        cfg_any_ff <= nxt_cfg_any;
        cfg_gnd_ff <= nxt_cfg_gnd;
        busy_oe_ff <= nxt_busy_oe;
        shared_request_n_oe_ff <= nxt_shared_request_n_oe;
        parallel_request_n_n_ff  <= nxt_parallel_request_n_n;
        priority_out_n_n_ff  <= nxt_priority_out_n_n;
        ctrl_oe_ff <= nxt_ctrl_oe;
        addr_n_ff  <= nxt_addr_n;
        dat_n_ff   <= nxt_dat_n;
        dat_oe_ff  <= nxt_dat_oe;
        cmd_n_ff   <= nxt_cmd_n;
        ube_n_ff   <= nxt_ube_n;
        hold_n_ff  <= nxt_hold_n;
    end

    // Open-drain lines only ever pull low
    assign BUS_IN_USE_N_O      = 1'b0;
    assign SHARED_REQUEST_N_O  = 1'b0;
    assign BUS_IN_USE_N_OE     = busy_oe_ff;
    assign SHARED_REQUEST_N_OE = shared_request_n_oe_ff;
    assign PRIORITY_OUT_N      = priority_out_n_n_ff;
    assign PARALLEL_REQUEST_N  = parallel_request_n_n_ff;
    assign CTRL_OE             = ctrl_oe_ff;
    assign ADDR_LINES_N        = addr_n_ff;
    assign DATA_LINES_N_O      = dat_n_ff;
    assign DATA_LINES_N_OE     = dat_oe_ff;
    assign MEM_READ_CMD_N      = cmd_n_ff[sbm_pkg::KIND_MEM_RD];
    assign MEM_WRITE_CMD_N     = cmd_n_ff[sbm_pkg::KIND_MEM_WR];
    assign IO_READ_CMD_N       = cmd_n_ff[sbm_pkg::KIND_IO_RD];
    assign IO_WRITE_CMD_N      = cmd_n_ff[sbm_pkg::KIND_IO_WR];
    assign INTR_ACK_N          = cmd_n_ff[sbm_pkg::KIND_INTR_ACK_N];
    assign UPPER_BYTE_ENABLE_N = ube_n_ff;
    assign RESOURCE_HOLD_N     = hold_n_ff;

    // ---------------- Checks on the bus side ----------------
    logic cmd_any;   // Some command line is low
    assign cmd_any = (cmd_n_ff != sbm_pkg::CMD_IDLE_N);

    default clocking b_cb @(posedge BUS_CLK);
    endclocking
    default disable iff (!b_rst_n);

    a_cmd_owned:   assert property (cmd_any |-> busy_oe_ff && ctrl_oe_ff)
        else $error("command without bus ownership");
    a_one_cmd:     assert property ($onehot0(~cmd_n_ff))
        else $error("more than one command line low");
    a_addr_setup:  assert property ($rose(cmd_any) |-> $past(ctrl_oe_ff, 3) && $stable(addr_n_ff))
        else $error("command before address settled");
    a_cmd_waits:   assert property (cmd_any && transfer_done_n_s_n |=> cmd_any)
        else $error("command ended before transfer done");
    a_cmd_ends:    assert property (cmd_any && !transfer_done_n_s_n |=> !cmd_any ##1 !cmd_any)
        else $error("command not ended after transfer done");
    a_shared_request_n_drop:   assert property (busy_oe_ff |-> !shared_request_n_oe_ff)
        else $error("shared request held while owning");
    a_take_free:   assert property ($rose(busy_oe_ff) |-> $past(busy_s_n) && !$past(prio_s_n))
        else $error("bus taken while busy or without priority");
    a_gnd_release: assert property (cfg_gnd_ff && $fell(cmd_any) |-> ##[1:10] !busy_oe_ff)
        else $error("bus kept after transfer with shared request grounded");
    a_need_req:    assert property (pend_ff |-> !parallel_request_n_n_ff && priority_out_n_n_ff)
        else $error("request lines idle while transfer pending");
    a_wr_data:     assert property (!cmd_n_ff[sbm_pkg::KIND_MEM_WR] |-> dat_oe_ff && dat_n_ff == ~wdata_ff)
        else $error("write data not driven inverted");
    a_ube_lane:    assert property (cmd_any |-> ube_n_ff == ~ube_ff)
        else $error("upper byte enable does not match request");

    c_mem_read:  cover property (!cmd_n_ff[sbm_pkg::KIND_MEM_RD] ##1 cmd_n_ff[sbm_pkg::KIND_MEM_RD]);
    c_park:      cover property (st_ff == sbm_pkg::ST_PARK ##1 st_ff == sbm_pkg::ST_SETUP);
    c_share_req: cover property ($rose(shared_request_n_oe_ff));
    c_prio_lost: cover property (busy_oe_ff && prio_s_n ##1 !busy_oe_ff);

endmodule : sbm_master

`default_nettype wire

// file: sbm_pkg.sv
/*
 * Shared constants for the system bus master: widths, transfer kinds,
 * bus-side state codes and timing counts.
 * Assumes a 200 MHz core clock and a slower free-running bus clock.
 */
`default_nettype none

package sbm_pkg;

    // Bus widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int KIND_W = 3;
    localparam int CMD_W  = 5;
    localparam int CNT_W  = 4;

    // Transfer kinds, also the bit index of the matching command line
    localparam logic [KIND_W-1:0] KIND_MEM_RD = 3'h0;
    localparam logic [KIND_W-1:0] KIND_MEM_WR = 3'h1;
    localparam logic [KIND_W-1:0] KIND_IO_RD  = 3'h2;
    localparam logic [KIND_W-1:0] KIND_IO_WR  = 3'h3;
    localparam logic [KIND_W-1:0] KIND_INTR_ACK_N   = 3'h4;

    // Timing, counted in bus clock cycles at no more than the core rate
    localparam int CLK_PERIOD_NS  = 5;
    localparam int ADDR_SETUP_NS  = 50;
    localparam int CMD_RECOV_NS   = 30;
    localparam logic [CNT_W-1:0] ADDR_SETUP_CYC = CNT_W'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CMD_RECOV_CYC  = CNT_W'((CMD_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Reset values
    localparam logic [CMD_W-1:0]  CMD_IDLE_N = 5'h1f;
    localparam logic [ADDR_W-1:0] ADDR_IDLE  = 20'h00000;

    // Bus-side sequencer states
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ARB   = 6'h02,
        ST_SETUP = 6'h04,
        ST_CMD   = 6'h08,
        ST_RECOV = 6'h10,
        ST_PARK  = 6'h20
    } sbm_state_t;

endpackage : sbm_pkg

`default_nettype wire

// file: sbm_slave_model.sv
/* Backplane slave: answers commands, serves reads, logs the last transfer.
   Assumes active-low command lines clocked by the bus clock. */
`default_nettype none
module sbm_slave_model (
    input  wire logic        bclk,
    input  wire logic [4:0]  cmd_n,
    input  wire logic [19:0] addr_n,
    input  wire logic [15:0] dout_n,
    input  wire logic        doe,
    input  wire logic [1:0]  lat,
    output var  logic        done_n,
    output var  logic [15:0] din_n,
    output var  logic [2:0]  kind,
    output var  logic [19:0] addr,
    output var  logic [15:0] wdat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt = 4'h0;   // Cycles since command
    logic [15:0] junk = 16'h0; // Filler when undriven
    initial done_n = 1'b1;
    // Delayed acknowledge and capture
    always @(posedge bclk)
    begin
        junk <= junk + 16'h3b1d;
        if (&cmd_n)
        begin
            cnt    <= 4'h0;
            done_n <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 4'h1;
            if (cnt == {2'h0, lat})
            begin
                done_n <= 1'b0;
                addr   <= ~addr_n;
                wdat   <= ~dout_n;
                for (int i = 0; i < 5; i++) if (!cmd_n[i]) kind <= 3'(i);
            end
        end
    end
    // Read data only while acknowledging a read
    assign din_n = doe ? dout_n : (!done_n && !(cmd_n[0] & cmd_n[2] & cmd_n[4])) ?
                   ~(addr[15:0] ^ 16'h5a5a) : junk;
endmodule : sbm_slave_model
`default_nettype wire

// file: sbm_sync.sv
/*
 * Two-stage synchroniser for a vector of levels.
 * Assumes each bit is a level that stays put for several destination cycles.
 */
`default_nettype none

module sbm_sync #(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_ff;   // First stage, read only by the second
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    // Next values
    always_comb
    begin
        nxt_meta = rst_n ? d : RST_VAL;
        nxt_q    = rst_n ? meta_ff : RST_VAL;
    end

    // Two flops in a row
    always_ff @(posedge clk)
    begin
        meta_ff <= nxt_meta;
        q       <= nxt_q;
    end

endmodule : sbm_sync

`default_nettype wire

// file: testbench.sv
/* Bench for the bus master: random transfers in all three arbitration modes.
   Assumes the slave model and a second master driven here. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, bclk = 1'b0, nrst = 1'b0, any_m = 1'b0, grnd = 1'b0, vld = 1'b0;
    logic ube = 1'b0, hold = 1'b0, pri_n = 1'b0, o_busy = 1'b0, o_req = 1'b0;
    logic [2:0]  kind = 3'h0;
    logic [19:0] addr = 20'h0;
    logic [15:0] wd = 16'h0;
    logic [1:0]  lat = 2'h1;
    wire logic rdy, rv, pro_n, preq_n, bu_o, bu_oe, sr_o, sr_oe, done_n, ctl_oe, doe, ube_n, rh_n;
    wire logic [15:0] rd, do_n, di_n, m_wd;
    wire logic [19:0] a_n, m_a;
    wire logic [4:0]  cmd_n;
    wire logic [2:0]  m_k;
    wire logic bu_i = (bu_oe ? bu_o : 1'b1) & ~o_busy; // Open-drain busy
    wire logic sr_i = (sr_oe ? sr_o : 1'b1) & ~o_req;  // Open-drain shared request
    int seed = 32'h3a074bfd, n_errors = 0, comparisons = 0, cyc = 0;
    always #2.5 clk = ~clk;
    initial begin #1.7; forever #3 bclk = ~bclk; end
    sbm_master i_dut (.CLK(clk), .NRST(nrst), .BUS_CLK(bclk), .ANY_REQUEST_MODE(any_m),
        .SHARED_REQ_GROUNDED(grnd), .REQ_VALID(vld), .REQ_READY(rdy), .REQ_KIND(kind), .REQ_ADDR(addr),
        .REQ_WDATA(wd), .REQ_UPPER_BYTE(ube), .REQ_HOLD(hold), .RSP_VALID(rv), .RSP_RDATA(rd),
        .PRIORITY_IN_N(pri_n), .PRIORITY_OUT_N(pro_n), .PARALLEL_REQUEST_N(preq_n), .BUS_IN_USE_N_I(bu_i),
        .BUS_IN_USE_N_O(bu_o), .BUS_IN_USE_N_OE(bu_oe), .SHARED_REQUEST_N_I(sr_i), .SHARED_REQUEST_N_O(sr_o),
        .SHARED_REQUEST_N_OE(sr_oe), .TRANSFER_DONE_N(done_n), .CTRL_OE(ctl_oe), .ADDR_LINES_N(a_n),
        .DATA_LINES_N_I(di_n), .DATA_LINES_N_O(do_n), .DATA_LINES_N_OE(doe), .MEM_READ_CMD_N(cmd_n[0]),
        .MEM_WRITE_CMD_N(cmd_n[1]), .IO_READ_CMD_N(cmd_n[2]), .IO_WRITE_CMD_N(cmd_n[3]),
        .INTR_ACK_N(cmd_n[4]), .UPPER_BYTE_ENABLE_N(ube_n), .RESOURCE_HOLD_N(rh_n));
    sbm_slave_model i_slv (.bclk(bclk), .cmd_n(cmd_n), .addr_n(a_n), .dout_n(do_n), .doe(doe), .lat(lat),
        .done_n(done_n), .din_n(di_n), .kind(m_k), .addr(m_a), .wdat(m_wd));
    // Compare and count
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] s);
        comparisons++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Verdict and end of run
    task finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    // One request, wait for its answer, check the far side
    task automatic xfer(input logic [2:0] k, input logic [19:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 300) begin @(negedge clk); n++; end
        kind = k;
        addr = a;
        wd = d;
        lat = 2'($random(seed));
        ube = 1'($random(seed));
        hold = 1'($random(seed));
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        n = 0;
        while (rv !== 1'b1 && n < 500) begin @(negedge clk); n++; end
        chk("answer", 20'h1, 20'(rv));
        chk("ready", 20'h1, 20'(rdy));
        chk("ctrl_oe", 20'h1, 20'(ctl_oe));
        chk("ube_n", 20'(!ube), 20'(ube_n));
        chk("hold_n", 20'(!hold), 20'(rh_n));
        chk("kind", 20'(k), 20'(m_k));
        if (k != 3'h4) chk("addr", a, m_a);
        if (k[0] && k != 3'h4) chk("wdata", 20'(d), 20'(m_wd));
        else chk("rdata", 20'(a[15:0] ^ 16'h5a5a), 20'(rd));
    endtask : xfer
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin n_errors++; finish_test(); end
    end
    initial
    begin
        for (int m = 0; m < 3; m++)
        begin
            nrst = 1'b0;
            any_m = m != 0;
            grnd = m == 2;
            repeat (16) @(negedge clk);
            nrst = 1'b1;
            repeat (30) @(negedge clk);
            xfer(3'h1, 20'hfffff, 16'h8001);
            xfer(3'h0, 20'hfffff, 16'h0000);
            for (int i = 0; i < 10; i++) xfer(3'($unsigned($random(seed)) % 5), 20'($random(seed)), 16'($random(seed)));
            repeat (60) @(negedge clk);
            chk("own", 20'(m == 1), 20'(bu_oe));
            chk("pri_pass", 20'(m == 1), 20'(pro_n));
            if (m == 1)
            begin
                o_req = 1'b1;
                repeat (60) @(negedge clk);
                chk("yield", 20'h0, 20'(bu_oe));
                o_req = 1'b0;
            end
            if (m == 0)
            begin
                o_busy = 1'b1;
                pri_n = 1'b1;
                fork
                    xfer(3'h3, 20'h12345, 16'h00ff);
                    begin
                        repeat (60) @(negedge clk);
                        chk("wait_req", 20'h1, 20'(sr_oe));
                        chk("no_take", 20'h0, 20'(bu_oe));
                        chk("par_req", 20'h0, 20'(preq_n));
                        chk("pri_out", 20'h1, 20'(pro_n));
                        o_busy = 1'b0;
                        repeat (30) @(negedge clk);
                        chk("no_prio", 20'h0, 20'(bu_oe));
                        pri_n = 1'b0;
                    end
                join
                chk("req_drop", 20'h0, 20'(sr_oe));
            end
            $display("test mode %0d done", m);
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire
